/* tb_watchdog_index_port_timer.sv */
// Self-checking bench for the watchdog behind the index/data port pair
`timescale 1ns/1ns
module tb_watchdog_index_port_timer;
  import wdt_pkg::*;
  localparam int MSC = 4; // Short millisecond keeps the run brief
  logic       clk_sys = 1'b0;
  logic       reset_n = 1'b0;
  io_req_s    io_req = '0;
  logic       kbd_activity = 1'b0;
  logic       mouse_activity = 1'b0;
  logic [7:0] io_rdata;
  logic       io_rvalid;
  logic       wdt_timeout;
  logic [7:0] v, m;
  int         fail_count = 0;
  int         total_checks = 0;
  int         n, cyc;

  watchdog_index_port_timer #(.MS_CYC(MSC)) i_watchdog_index_port_timer (
    .clk_sys(clk_sys), .reset_n(reset_n), .io_req(io_req),
    .kbd_activity(kbd_activity), .mouse_activity(mouse_activity),
    .io_rdata(io_rdata), .io_rvalid(io_rvalid), .wdt_timeout(wdt_timeout));

  always #4 clk_sys = ~clk_sys;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Cycles from reload to expiry for a count, unit and speed
  function automatic int exp_cyc(int cnt, logic mins, logic fast);
    return cnt * MSC * (fast ? 1 : MS_PER_SEC) * (mins ? SEC_PER_MIN : 1);
  endfunction : exp_cyc

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // One idle cycle between accesses avoids double drives in one step
  task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    io_req <= '{1'b1, 1'b0, a, d};
    @(negedge clk_sys);
    io_req <= '0;
  endtask : io_wr

  task automatic io_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    io_req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge clk_sys);
    io_req <= '0;
    chk(io_rvalid, a == PORT_DATA);
    d = io_rdata;
  endtask : io_rd

  task automatic reg_wr(input logic [7:0] i, input logic [7:0] d);
    io_wr(PORT_INDEX, i);
    io_wr(PORT_DATA, d);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] i, output logic [7:0] d);
    io_wr(PORT_INDEX, i);
    io_rd(PORT_DATA, d);
  endtask : reg_rd

  // Bounded wait for expiry; running out ends the run
  task automatic wait_to(input int lim, output int c);
    c = 0;
    while (wdt_timeout !== 1'b1) begin
      @(negedge clk_sys);
      c++;
      if (c > lim) begin
        fail_count++;
        wrap_up();
      end
    end
  endtask : wait_to

  task automatic pulse(input logic kb, input logic ms);
    @(negedge clk_sys);
    kbd_activity   <= kb;
    mouse_activity <= ms;
    repeat (3) @(negedge clk_sys);
    kbd_activity   <= 1'b0;
    mouse_activity <= 1'b0;
  endtask : pulse

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h744BF864));
    repeat (10) @(negedge clk_sys);
    reset_n <= 1'b1;
    chk(wdt_timeout, 1'b0);
    io_rd(PORT_DATA, v);
    chk(v, 8'h00);
    io_rd(8'h80, v);
    io_wr(PORT_INDEX, KEY_UNLOCK);
    io_wr(PORT_INDEX, KEY_UNLOCK);
    reg_wr(IDX_LDN_SEL, WDT_LDN);
    reg_wr(IDX_ACTIVATE, 8'h01);
    // Unit register untouched: reset value must mean whole seconds
    reg_wr(IDX_COUNT, 8'h01);
    wait_to(exp_cyc(1, 1'b0, 1'b0) + 8, cyc);
    chk(cyc >= exp_cyc(1, 1'b0, 1'b0) - 3, 1'b1);
    reg_rd(IDX_CTRL, v);
    chk(v[CTRL_STAT_BIT], 1'b1);
    // Fast seconds and minutes, with both count boundaries
    for (int i = 0; i < 4; i++) begin
      // Twenty fast minutes cross the millisecond counter's wrap
      n = (i == 3) ? 1 : (i == 2) ? 255 :
          (i == 1) ? 20 : $urandom_range(2, 20);
      m = {3'b000, 1'b1, i[0], 3'b000};
      reg_wr(IDX_UNIT, m);
      reg_wr(IDX_COUNT, n[7:0]);
      chk(wdt_timeout, 1'b0);
      wait_to(exp_cyc(n, m[3], 1'b1) + 4, cyc);
      chk(cyc >= exp_cyc(n, m[3], 1'b1) - 3, 1'b1);
    end
    reg_wr(IDX_UNIT, 8'h10);
    reg_wr(IDX_ACTIVATE, 8'h00);
    chk(wdt_timeout, 1'b0);
    reg_wr(IDX_COUNT, 8'h02);
    repeat (300) @(negedge clk_sys);
    chk(wdt_timeout, 1'b0);
    reg_wr(IDX_COUNT, 8'h00);
    reg_wr(IDX_ACTIVATE, 8'h01);
    repeat (300) @(negedge clk_sys);
    chk(wdt_timeout, 1'b0);
    // Forced expiry, then lock, broken key and device select gating
    m = 8'($urandom_range(0, 3) << 6);
    reg_wr(IDX_CTRL, m | 8'h20);
    @(negedge clk_sys);
    chk(wdt_timeout, 1'b1);
    pulse(1'b1, 1'b1);
    chk(wdt_timeout, 1'b1);
    reg_rd(IDX_CTRL, v);
    chk(v, m | 8'h10);
    io_wr(PORT_INDEX, KEY_LOCK);
    io_rd(PORT_DATA, v);
    chk(v, 8'h00);
    reg_wr(IDX_COUNT, 8'h05);
    chk(wdt_timeout, 1'b1);
    io_wr(PORT_INDEX, KEY_UNLOCK);
    io_wr(PORT_INDEX, 8'h55);
    io_wr(PORT_INDEX, KEY_UNLOCK);
    io_rd(PORT_DATA, v);
    chk(v, 8'h00);
    io_wr(PORT_INDEX, KEY_UNLOCK);
    reg_rd(IDX_CTRL, v);
    chk(v, m | 8'h10);
    reg_wr(IDX_LDN_SEL, WDT_LDN ^ 8'($urandom_range(1, 255)));
    reg_rd(IDX_CTRL, v);
    chk(v, 8'h00);
    reg_wr(IDX_COUNT, 8'h05);
    chk(wdt_timeout, 1'b1);
    reg_wr(IDX_LDN_SEL, WDT_LDN);
    reg_rd(8'h55, v);
    chk(v, 8'h00);
    // Strobe table: only the enabled source reloads the count
    for (int i = 0; i < 4; i++) begin
      reg_wr(IDX_CTRL, i[0] ? 8'h80 : 8'h40);
      reg_wr(IDX_COUNT, 8'h14);
      chk(wdt_timeout, 1'b0);
      repeat (50) @(negedge clk_sys);
      pulse(!(i[0] ^ i[1]), i[0] ^ i[1]);
      repeat (exp_cyc(20, 1'b0, 1'b1) - 33) @(negedge clk_sys);
      chk(wdt_timeout, i[1]);
      wait_to(100, cyc);
    end
    wrap_up();
  end
endmodule : tb_watchdog_index_port_timer

/* watchdog_index_port_timer.sv */
// Watchdog timer behind an index/data host I/O port pair
//
// Overview of operation
// - Two host I/O addresses: index port takes register index, next one data.
// - Two successive unlock key writes to index port open configuration.
// - Lock key written to index port returns interface to locked.
// - Device-select register holding watchdog number maps watchdog registers.
// - Activation bit enables watchdog; disabled out of reset.
// - Unit bit chooses seconds when clear, minutes when set.
// - Fast bit makes each count a thousandth of a second or minute.
// - Count zero stops timer; one to maximum sets timeout length.
// - Count elapsing without reload or strobe asserts the timeout output.
// - Any count register write restarts countdown from new value.
// - Keyboard strobe enable bit lets keyboard activity reload timer.
// - Force bit gives immediate timeout and clears itself.
// - Readable status bit shows one after timeout.
// - Mouse strobe enable bit lets mouse activity reload timer.
`timescale 1ns/1ns
module watchdog_index_port_timer #(
  parameter int MS_CYC = wdt_pkg::MS_CYCLES
) (
  input  wire logic            clk_sys,
  input  wire logic            reset_n,
  input  wire wdt_pkg::io_req_s io_req,
  input  wire logic            kbd_activity,
  input  wire logic            mouse_activity,
  output logic [7:0]           io_rdata,
  output logic                 io_rvalid,
  output logic                 wdt_timeout
);
  import wdt_pkg::*;

  // Watchdog-set decode shared by the write strobes below
  function automatic logic wdt_hit(input logic       sel,
                                   input logic [7:0] idx,
                                   input logic [7:0] want);
    return sel && (idx == want);
  endfunction : wdt_hit

  // ---------------------------------------------------------------
  // Activity inputs arrive from outside the clock domain
  // ---------------------------------------------------------------
  logic kbd_s, mouse_s, kbd_d_reg, mouse_d_reg;
  logic kbd_edge, mouse_edge;

  wdt_sync2 u_kbd_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .d       (kbd_activity),
    .q       (kbd_s)
  );

  wdt_sync2 u_mouse_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .d       (mouse_activity),
    .q       (mouse_s)
  );

  // Edge detectors look only at synchronised levels
  // Reset value matches the idle low pin, so no false strobe after reset
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      kbd_d_reg   <= 1'b0;
      mouse_d_reg <= 1'b0;
    end else begin
      kbd_d_reg   <= kbd_s;
      mouse_d_reg <= mouse_s;
    end
  end

  assign kbd_edge   = kbd_s & ~kbd_d_reg;
  assign mouse_edge = mouse_s & ~mouse_d_reg;

  // ---------------------------------------------------------------
  // Key sequencer and index register
  // ---------------------------------------------------------------
  lock_e      lock_reg, lock_next;
  logic [7:0] index_reg, index_next;
  logic       idx_wr, dat_wr, dat_rd;

  // Any other host address is simply ignored
  assign idx_wr = io_req.wr && io_req.addr == PORT_INDEX;
  assign dat_wr = io_req.wr && io_req.addr == PORT_DATA;
  assign dat_rd = io_req.rd && io_req.addr == PORT_DATA;

  // While locked, index writes only feed the key detector
  always_comb begin
    lock_next  = lock_reg;
    index_next = index_reg;
    if (idx_wr) begin
      case (lock_reg)
        LK_LOCKED: begin
          if (io_req.data == KEY_UNLOCK) begin
            lock_next = LK_HALF;
          end
        end
        LK_HALF: begin
          // Second key must follow at once, else start over
          lock_next = (io_req.data == KEY_UNLOCK) ? LK_OPEN : LK_LOCKED;
        end
        LK_OPEN: begin
          if (io_req.data == KEY_LOCK) begin
            lock_next = LK_LOCKED;
          end else begin
            index_next = io_req.data;
          end
        end
        default: begin
          lock_next = LK_LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lock_reg  <= LK_LOCKED;
      index_reg <= RST_BYTE;
    end else begin
      lock_reg  <= lock_next;
      index_reg <= index_next;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [7:0] ldn_reg, ldn_next;
  logic       act_reg, act_next;
  logic       umin_reg, umin_next;
  logic       fast_reg, fast_next;
  logic [7:0] count_reg, count_next;
  logic       kben_reg, kben_next;
  logic       msen_reg, msen_next;
  logic       open, sel_wdt, cfg_wr;
  logic       count_wr, force_wr;

  // Locked data writes fall on the floor; nothing is kept for later
  assign open    = (lock_reg == LK_OPEN);
  assign cfg_wr  = dat_wr && open;
  assign sel_wdt = (ldn_reg == WDT_LDN);
  assign count_wr = cfg_wr && wdt_hit(sel_wdt, index_reg, IDX_COUNT);
  assign force_wr = cfg_wr && wdt_hit(sel_wdt, index_reg, IDX_CTRL)
                    && io_req.data[CTRL_FORCE_BIT];

  // Each watchdog register answers only when its device is selected
  always_comb begin
    ldn_next   = ldn_reg;
    act_next   = act_reg;
    umin_next  = umin_reg;
    fast_next  = fast_reg;
    count_next = count_reg;
    kben_next  = kben_reg;
    msen_next  = msen_reg;
    if (cfg_wr) begin
      if (index_reg == IDX_LDN_SEL) begin
        ldn_next = io_req.data;
      end else if (sel_wdt && index_reg == IDX_ACTIVATE) begin
        act_next = io_req.data[ACT_EN_BIT];
      end else if (sel_wdt && index_reg == IDX_UNIT) begin
        umin_next = io_req.data[UNIT_MIN_BIT];
        fast_next = io_req.data[UNIT_FAST_BIT];
      end else if (sel_wdt && index_reg == IDX_COUNT) begin
        count_next = io_req.data;
      end else if (sel_wdt && index_reg == IDX_CTRL) begin
        kben_next = io_req.data[CTRL_KB_BIT];
        msen_next = io_req.data[CTRL_MS_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ldn_reg   <= RST_BYTE;
      act_reg   <= 1'b0;
      umin_reg  <= 1'b0;
      fast_reg  <= 1'b0;
      count_reg <= RST_BYTE;
      kben_reg  <= 1'b0;
      msen_reg  <= 1'b0;
    end else begin
      ldn_reg   <= ldn_next;
      act_reg   <= act_next;
      umin_reg  <= umin_next;
      fast_reg  <= fast_next;
      count_reg <= count_next;
      kben_reg  <= kben_next;
      msen_reg  <= msen_next;
    end
  end

  // ---------------------------------------------------------------
  // Countdown and expiry
  // ---------------------------------------------------------------
  logic [7:0] remain_reg, remain_next;
  logic       stat_reg, stat_next;
  logic       tmo_reg, tmo_next;
  logic       strobe, reload, tick;

  // Strobes count as activity only when their enable is set
  assign strobe = (kben_reg && kbd_edge) || (msen_reg && mouse_edge);
  assign reload = count_wr || strobe;

  // Divider restarts on every reload so the first unit is always whole
  wdt_tick_gen #(
    .MS_CYC (MS_CYC)
  ) u_tick (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .restart  (reload),
    .unit_min (umin_reg),
    .fast     (fast_reg),
    .tick     (tick)
  );

  // A strobe reloads from the stored count; a write from the new value
  always_comb begin
    remain_next = remain_reg;
    stat_next   = stat_reg;
    if (count_wr) begin
      remain_next = io_req.data;
      stat_next   = 1'b0;
    end else if (strobe) begin
      remain_next = count_reg;
    end else if (act_reg && count_reg != RST_BYTE && tick
                 && remain_reg != RST_BYTE) begin
      remain_next = remain_reg - 8'h01;
      if (remain_reg == 8'h01) begin
        stat_next = 1'b1;
      end
    end
    // Look at the next enable so a disable write clears status at once,
    // in the same cycle as a count write would
    if (!act_next) begin
      stat_next = 1'b0;
    end
    // Force wins over any clear in the same cycle
    if (force_wr) begin
      stat_next = 1'b1;
    end
    tmo_next = stat_next;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      remain_reg <= RST_BYTE;
      stat_reg   <= 1'b0;
      tmo_reg    <= 1'b0;
    end else begin
      remain_reg <= remain_next;
      stat_reg   <= stat_next;
      tmo_reg    <= tmo_next;
    end
  end

  // A level, so an interrupt or reset controller can latch it at leisure
  assign wdt_timeout = tmo_reg;

  // ---------------------------------------------------------------
  // Data port read-back
  // ---------------------------------------------------------------
  logic [7:0] rdata_reg, rdata_next;
  logic       rvalid_reg, rvalid_next;

  // Reads answer even while locked, with zero data, so the host never waits
  // Force bit always reads zero since it clears itself
  always_comb begin
    rdata_next  = RST_BYTE;
    rvalid_next = dat_rd;
    if (dat_rd && open) begin
      if (index_reg == IDX_LDN_SEL) begin
        rdata_next = ldn_reg;
      end else if (sel_wdt && index_reg == IDX_ACTIVATE) begin
        rdata_next[ACT_EN_BIT] = act_reg;
      end else if (sel_wdt && index_reg == IDX_UNIT) begin
        rdata_next[UNIT_MIN_BIT]  = umin_reg;
        rdata_next[UNIT_FAST_BIT] = fast_reg;
      end else if (sel_wdt && index_reg == IDX_COUNT) begin
        rdata_next = count_reg;
      end else if (sel_wdt && index_reg == IDX_CTRL) begin
        rdata_next[CTRL_MS_BIT]   = msen_reg;
        rdata_next[CTRL_KB_BIT]   = kben_reg;
        rdata_next[CTRL_STAT_BIT] = stat_reg;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg  <= RST_BYTE;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign io_rdata  = rdata_reg;
  assign io_rvalid = rvalid_reg;

endmodule : watchdog_index_port_timer

/* watchdog_index_port_timer_sva.sv */
// Checker for the watchdog block's host port and timeout output
`timescale 1ns/1ns
module watchdog_index_port_timer_sva
  import wdt_pkg::*;
#(
  parameter int MS_CYC = wdt_pkg::MS_CYCLES
) (
  input wire logic             clk_sys,
  input wire logic             reset_n,
  input wire wdt_pkg::io_req_s io_req,
  input wire logic             kbd_activity,
  input wire logic             mouse_activity,
  input wire logic [7:0]       io_rdata,
  input wire logic             io_rvalid,
  input wire logic             wdt_timeout
);
  // ------------------------------------------------------------
  // Shadow of key state and watchdog registers
  // ------------------------------------------------------------
  logic       open_reg, half_reg, act_reg, counting;
  logic [7:0] idx_reg, ldn_reg, cnt_reg;
  logic       idx_wr, dat_wr, dat_rd, sel, w_force, w_count, w_act0, rd_ctrl;

  // Decoded host cycles; only the selected watchdog set matters
  assign idx_wr   = io_req.wr && io_req.addr == PORT_INDEX;
  assign dat_wr   = io_req.wr && io_req.addr == PORT_DATA;
  assign dat_rd   = io_req.rd && io_req.addr == PORT_DATA;
  assign sel      = open_reg && ldn_reg == WDT_LDN;
  assign w_force  = dat_wr && sel && idx_reg == IDX_CTRL
                    && io_req.data[CTRL_FORCE_BIT];
  assign w_count  = dat_wr && sel && idx_reg == IDX_COUNT;
  assign w_act0   = dat_wr && sel && idx_reg == IDX_ACTIVATE
                    && !io_req.data[ACT_EN_BIT];
  assign rd_ctrl  = dat_rd && sel && idx_reg == IDX_CTRL;
  assign counting = act_reg && cnt_reg != 8'h00;

  // Key detector: a non-key byte between the two keys starts over
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      {open_reg, half_reg, act_reg, idx_reg, ldn_reg, cnt_reg} <= '0;
    end else begin
      if (idx_wr && !open_reg) begin
        half_reg <= io_req.data == KEY_UNLOCK;
        open_reg <= half_reg && io_req.data == KEY_UNLOCK;
      end
      if (idx_wr && open_reg) begin
        open_reg <= io_req.data != KEY_LOCK;
        half_reg <= 1'b0;
        if (io_req.data != KEY_LOCK) begin
          idx_reg <= io_req.data;
        end
      end
      if (dat_wr && open_reg && idx_reg == IDX_LDN_SEL) begin
        ldn_reg <= io_req.data;
      end
      if (dat_wr && sel && idx_reg == IDX_ACTIVATE) begin
        act_reg <= io_req.data[ACT_EN_BIT];
      end
      if (w_count) begin
        cnt_reg <= io_req.data;
      end
    end
  end

  default clocking main_cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  read_answer_a: assert property (dat_rd |=> io_rvalid)
    else $error("No answer one cycle after a data port read");
  answer_cause_a: assert property (io_rvalid |-> $past(dat_rd))
    else $error("Read answer without a data port read");
  rdata_idle_a: assert property (!io_rvalid |-> io_rdata == 8'h00)
    else $error("Read data not zero outside an answer");
  locked_read_a: assert property (
    dat_rd && !open_reg |=> io_rdata == 8'h00)
    else $error("Locked read returned data");
  force_out_a: assert property (w_force |=> wdt_timeout)
    else $error("Forced timeout not seen one cycle later");
  count_clear_a: assert property (w_count |=> !wdt_timeout)
    else $error("Count write did not clear timeout");
  off_clear_a: assert property (w_act0 |=> !wdt_timeout)
    else $error("Disable did not clear timeout");
  status_hold_a: assert property (
    wdt_timeout && act_reg && !w_count && !w_act0 |=> wdt_timeout)
    else $error("Timeout dropped without reload or disable");
  timeout_cause_a: assert property (
    $rose(wdt_timeout) |-> $past(w_force) || $past(counting))
    else $error("Timeout rose while the timer was stopped");
  status_read_a: assert property (rd_ctrl |=>
    io_rdata[CTRL_STAT_BIT] == $past(wdt_timeout)
    && !io_rdata[CTRL_FORCE_BIT])
    else $error("Control read status bits wrong");
endmodule : watchdog_index_port_timer_sva

bind watchdog_index_port_timer watchdog_index_port_timer_sva #(
  .MS_CYC(MS_CYC)
) i_watchdog_index_port_timer_sva (
  .clk_sys(clk_sys), .reset_n(reset_n), .io_req(io_req),
  .kbd_activity(kbd_activity), .mouse_activity(mouse_activity),
  .io_rdata(io_rdata), .io_rvalid(io_rvalid), .wdt_timeout(wdt_timeout)
);

/* wdt_pkg.sv */
// Package with register map, keys, field layout and timing constants
package wdt_pkg;

  // ---------------------------------------------------------------
  // Host port addresses and keys
  // ---------------------------------------------------------------
  localparam logic [7:0] PORT_INDEX    = 8'h2E;
  localparam logic [7:0] PORT_DATA     = 8'h2F;
  localparam logic [7:0] KEY_UNLOCK    = 8'h87;
  localparam logic [7:0] KEY_LOCK      = 8'hAA;
  localparam logic [7:0] WDT_LDN       = 8'h08;

  // ---------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_LDN_SEL   = 8'h07;
  localparam logic [7:0] IDX_ACTIVATE  = 8'h30;
  localparam logic [7:0] IDX_UNIT      = 8'hF5;
  localparam logic [7:0] IDX_COUNT     = 8'hF6;
  localparam logic [7:0] IDX_CTRL      = 8'hF7;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int         ACT_EN_BIT    = 0;
  localparam int         UNIT_MIN_BIT  = 3;
  localparam int         UNIT_FAST_BIT = 4;
  localparam int         CTRL_MS_BIT   = 7;
  localparam int         CTRL_KB_BIT   = 6;
  localparam int         CTRL_FORCE_BIT = 5;
  localparam int         CTRL_STAT_BIT = 4;
  localparam logic [7:0] RST_BYTE      = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int         CLK_HZ        = 125_000_000;
  localparam int         TICK_MS       = 1;
  localparam int         MS_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int         MS_PER_SEC    = 1000;
  localparam int         SEC_PER_MIN   = 60;
  localparam int         FAST_DIV      = 1000;

  // Host I/O cycle carrier
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } io_req_s;

  typedef enum logic [1:0] {
    LK_LOCKED,
    LK_HALF,
    LK_OPEN
  } lock_e;

endpackage : wdt_pkg

/* wdt_sync2.sv */
// Two-flop synchroniser for an asynchronous level
`timescale 1ns/1ns
module wdt_sync2 (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic d,
  output logic      q
);
  logic s1_reg, s2_reg;

  // Only the second stage is visible outside
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
    end
  end

  assign q = s2_reg;

endmodule : wdt_sync2

/* wdt_tick_gen.sv */
// Tick divider producing a one-cycle count enable per selected unit
`timescale 1ns/1ns
module wdt_tick_gen #(
  parameter int MS_CYC = wdt_pkg::MS_CYCLES
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic restart,
  input  wire logic unit_min,
  input  wire logic fast,
  output logic      tick
);
  import wdt_pkg::*;

  logic [16:0] cyc_reg, cyc_next;
  logic [9:0]  ms_reg, ms_next;
  logic [5:0]  sec_reg, sec_next;
  logic [5:0]  fm_reg, fm_next;
  logic        tick_reg, tick_next;
  logic        ms_p, sec_p, min_p, fm_p;

  // ---------------------------------------------------------------
  // Cascade: cycles -> ms -> s -> min
  // ---------------------------------------------------------------
  // Restart zeroes the chain so a reload always gets a full first unit
  always_comb begin
    cyc_next = cyc_reg + 17'h00001;
    ms_next  = ms_reg;
    sec_next = sec_reg;
    fm_next  = fm_reg;
    ms_p     = 1'b0;
    sec_p    = 1'b0;
    min_p    = 1'b0;
    fm_p     = 1'b0;
    if (cyc_reg == 17'(MS_CYC - 1)) begin
      cyc_next = '0;
      ms_p     = 1'b1;
      ms_next  = ms_reg + 10'h001;
      // Own 60 ms counter: 1000 ms is no multiple of 60, so the ms count
      // cannot mark fast minutes evenly across its wrap
      fm_next  = fm_reg + 6'h01;
      if (fm_reg == 6'(SEC_PER_MIN - 1)) begin
        fm_next = '0;
        fm_p    = 1'b1;
      end
      if (ms_reg == 10'(MS_PER_SEC - 1)) begin
        ms_next  = '0;
        sec_p    = 1'b1;
        sec_next = sec_reg + 6'h01;
        if (sec_reg == 6'(SEC_PER_MIN - 1)) begin
          sec_next = '0;
          min_p    = 1'b1;
        end
      end
    end
    // Fast mode: one ms per fast second, 60 ms per fast minute
    if (fast) begin
      tick_next = unit_min ? fm_p : ms_p;
    end else begin
      tick_next = unit_min ? min_p : sec_p;
    end
    if (restart) begin
      cyc_next  = '0;
      ms_next   = '0;
      sec_next  = '0;
      fm_next   = '0;
      tick_next = 1'b0;
    end
  end

  // Divider registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cyc_reg  <= '0;
      ms_reg   <= '0;
      sec_reg  <= '0;
      fm_reg   <= '0;
      tick_reg <= 1'b0;
    end else begin
      cyc_reg  <= cyc_next;
      ms_reg   <= ms_next;
      sec_reg  <= sec_next;
      fm_reg   <= fm_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule : wdt_tick_gen
